// File: design/bit_literal_pkg.sv
// Functional notes
// - Opcode 01 10bb bfff ffff tests bit b of file f and skips the next word when it is zero, costing two cycles.
// - Opcode 01 11bb bfff ffff tests bit b of file f and skips the next word when it is one, costing two cycles.
// - A change of program counter or a true conditional test costs two cycles, as for the call and branch forms.
// - The second cycle of a two-cycle instruction is a no-op that changes no register, flag or memory.
// - Reading the I/O port register as a source takes the pin levels, not the output latch.
// - An instruction's file write to the timer count clears the prescaler when the prescaler is assigned to that timer; a REG_FDATA write does not.
// - The nibble exchange puts source bits 3:0 in result bits 7:4 and bits 7:4 in 3:0, with no flag change.
// - A destination bit of 0 sends the result to the working register, 1 sends it back to the file register.
// - The file exclusive-OR combines the working register with file f (0 to 127) and updates only zero.
// - The literal exclusive-OR (11 1010) folds an eight-bit literal into the working register, zero only.
// - The literal OR (11 1000) folds an eight-bit literal into the working register in one cycle, zero only.
// - The literal minus (11 110x) loads literal minus working register, updating carry, half carry and zero.
// - The literal return (11 01xx) loads the literal into the working register and returns, in two cycles.
// - The standby opcode 00 0000 0110 0011 enters standby in one cycle and updates both watchdog flags.
package bit_literal_pkg;

  typedef enum logic [4:0] {
    no_operation_op,
    nibble_exchange_op,
    acc_file_xor_op,
    bit_clear_op,
    bit_set_op,
    test_skip_clear_op,
    test_skip_set_op,
    subroutine_jump_op,
    branch_op,
    literal_add_op,
    literal_and_op,
    literal_load_op,
    literal_or_op,
    literal_xor_op,
    literal_minus_acc_op,
    return_literal_op,
    plain_return_op,
    interrupt_return_op,
    standby_op,
    watchdog_kick_op
  } instr_class_t;

  typedef enum logic {st_ready, st_flush} exec_state_t;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INSTR = 8'h04;
  localparam logic [7:0] REG_WORK = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_FADDR = 8'h14;
  localparam logic [7:0] REG_FDATA = 8'h18;

  // Control bits
  localparam int CTRL_PRESC_TIMER = 0;
  localparam int CTRL_WAKE = 1;
  localparam int CTRL_GIE = 2;

  // Status bits
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_HALF_CARRY = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_SLEEP_ENTERED = 3;
  localparam int FLAG_WATCHDOG_EXPIRED = 4;
  localparam int STAT_BUSY = 8;
  localparam int STAT_SLEEP = 9;
  localparam int STAT_GIE = 10;
  localparam logic [4:0] FLAGS_RESET = 5'h18;

  // File addresses with side effects
  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
  localparam logic [6:0] IO_PORT_ADDR = 7'h06;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res;
  endfunction

endpackage

// File: design/bit_literal_alu.sv
`timescale 1ns/1ps
`default_nettype none
module bit_literal_alu
  import bit_literal_pkg::*;
(
  // Operation
  input wire instr_class_t cls,
  input wire logic [7:0] src,
  input wire logic [7:0] acc,
  input wire logic [2:0] bit_sel,
  // Result
  output logic [7:0] result,
  output logic carry,
  output logic half_carry,
  output logic zero
);

  logic [8:0] sum9;
  logic [4:0] half5;

  always_comb begin
    sum9 = 9'h000;
    half5 = 5'h00;
    result = src;
    carry = 1'b0;
    half_carry = 1'b0;
    case (cls)
      nibble_exchange_op: begin
        result = {src[3:0], src[7:4]};
      end
      acc_file_xor_op, literal_xor_op: begin
        result = src ^ acc;
      end
      literal_or_op: begin
        result = src | acc;
      end
      literal_and_op: begin
        result = src & acc;
      end
      literal_add_op: begin
        sum9 = {1'b0, src} + {1'b0, acc};
        half5 = {1'b0, src[3:0]} + {1'b0, acc[3:0]};
        result = sum9[7:0];
        carry = sum9[8];
        half_carry = half5[4];
      end
      literal_minus_acc_op: begin
        // Carry high means no borrow
        sum9 = {1'b0, src} + {1'b0, ~acc} + 9'h001;
        half5 = {1'b0, src[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
        result = sum9[7:0];
        carry = sum9[8];
        half_carry = half5[4];
      end
      bit_clear_op: begin
        result = src & ~(8'h01 << bit_sel);
      end
      bit_set_op: begin
        result = src | (8'h01 << bit_sel);
      end
      default: begin
        result = src;
      end
    endcase
    zero = (result == 8'h00);
  end

endmodule
`default_nettype wire

// File: design/bit_literal_control_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module bit_literal_control_decoder
  import bit_literal_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core side
  input wire logic [7:0] pin_level,
  output logic [7:0] port_latch,
  output logic prescaler_clear,
  output logic watchdog_restart,
  output logic sleep_state,
  output logic interrupts_enabled
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  typedef struct packed {
    exec_state_t st;
    logic [7:0] wreg;
    logic [4:0] flags;
    logic [12:0] pc;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][12:0] stack;
    logic [127:0][7:0] mem;
    logic [13:0] ir;
    logic [6:0] faddr;
    logic presc_assigned;
    logic gie;
    logic sleep;
    logic presc_clear;
    logic wdt_restart;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t s_reg;
  state_t s_next;

  function automatic instr_class_t decode(input logic [13:0] ir);
    instr_class_t c;
    c = no_operation_op;
    case (ir[13:12])
      2'b00: begin
        if (ir[11:8] == 4'b1110) c = nibble_exchange_op;
        else if (ir[11:8] == 4'b0110) c = acc_file_xor_op;
        else if (ir == 14'h0063) c = standby_op;
        else if (ir == 14'h0064) c = watchdog_kick_op;
        else if (ir == 14'h0008) c = plain_return_op;
        else if (ir == 14'h0009) c = interrupt_return_op;
      end
      2'b01: begin
        case (ir[11:10])
          2'b00: c = bit_clear_op;
          2'b01: c = bit_set_op;
          2'b10: c = test_skip_clear_op;
          default: c = test_skip_set_op;
        endcase
      end
      2'b10: begin
        c = ir[11] ? branch_op : subroutine_jump_op;
      end
      default: begin
        casez (ir[11:8])
          4'b111?: c = literal_add_op;
          4'b1001: c = literal_and_op;
          4'b00??: c = literal_load_op;
          4'b1000: c = literal_or_op;
          4'b1010: c = literal_xor_op;
          4'b110?: c = literal_minus_acc_op;
          4'b01??: c = return_literal_op;
          default: c = no_operation_op;
        endcase
      end
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Issue and operand selection

  logic wr_go;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic issue;
  logic [13:0] ir_new;
  logic [31:0] instr_merged;
  instr_class_t cls;
  logic [6:0] file_idx;
  logic [2:0] bsel;
  logic [7:0] fval;
  logic [7:0] src;
  logic file_we;
  logic skip_bit;
  logic [7:0] src_swapped;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;

  // Writes wait out the no-op cycle so nothing changes during it
  assign wr_go = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid && (s_reg.st == st_ready);
  assign wr_addr = {s_reg.aw_addr[7:2], 2'b00};
  assign rd_addr = {araddr[7:2], 2'b00};
  assign instr_merged = merge_bytes({18'h0, s_reg.ir}, s_reg.w_data, s_reg.w_strb);
  assign ir_new = instr_merged[13:0];
  assign issue = wr_go && (wr_addr == REG_INSTR) && !s_reg.sleep;
  assign cls = decode(ir_new);
  assign file_idx = ir_new[6:0];
  assign bsel = ir_new[9:7];
  assign fval = (file_idx == IO_PORT_ADDR) ? pin_level : s_reg.mem[file_idx];
  assign src = (ir_new[13:12] == 2'b11) ? ir_new[7:0] : fval;
  assign skip_bit = src[bsel];
  assign src_swapped = {src[3:0], src[7:4]};
  assign file_we = issue && ((cls == bit_clear_op) || (cls == bit_set_op) ||
                   (((cls == nibble_exchange_op) || (cls == acc_file_xor_op)) && ir_new[7]));

  bit_literal_alu alu_i (
    .cls(cls),
    .src(src),
    .acc(s_reg.wreg),
    .bit_sel(bsel),
    .result(alu_res),
    .carry(alu_c),
    .half_carry(alu_dc),
    .zero(alu_z)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [31:0] wv;
    wv = 32'h00000000;
    s_next = s_reg;
    s_next.presc_clear = 1'b0;
    s_next.wdt_restart = 1'b0;
    if (s_reg.st == st_flush) begin
      s_next.st = st_ready;
    end
    if (awvalid && awready) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_next.w_got = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      case (rd_addr)
        REG_CTRL: s_next.rdata = {29'h0, s_reg.gie, 1'b0, s_reg.presc_assigned};
        REG_INSTR: s_next.rdata = {18'h0, s_reg.ir};
        REG_WORK: s_next.rdata = {24'h0, s_reg.wreg};
        REG_STATUS: s_next.rdata = {21'h0, s_reg.gie, s_reg.sleep, s_reg.st == st_flush,
                                    3'h0, s_reg.flags};
        REG_PC: s_next.rdata = {19'h0, s_reg.pc};
        REG_FADDR: s_next.rdata = {25'h0, s_reg.faddr};
        REG_FDATA: s_next.rdata = {24'h0, s_reg.mem[s_reg.faddr]};
        default: begin
          s_next.rdata = 32'h00000000;
          s_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (wr_go) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      case (wr_addr)
        REG_CTRL: begin
          wv = merge_bytes({29'h0, s_reg.gie, 1'b0, s_reg.presc_assigned},
                           s_reg.w_data, s_reg.w_strb);
          s_next.presc_assigned = wv[CTRL_PRESC_TIMER];
          s_next.gie = wv[CTRL_GIE];
          if (wv[CTRL_WAKE]) s_next.sleep = 1'b0;
        end
        REG_WORK: begin
          wv = merge_bytes({24'h0, s_reg.wreg}, s_reg.w_data, s_reg.w_strb);
          s_next.wreg = wv[7:0];
        end
        REG_FADDR: begin
          wv = merge_bytes({25'h0, s_reg.faddr}, s_reg.w_data, s_reg.w_strb);
          s_next.faddr = wv[6:0];
        end
        REG_FDATA: begin
          wv = merge_bytes({24'h0, s_reg.mem[s_reg.faddr]}, s_reg.w_data, s_reg.w_strb);
          s_next.mem[s_reg.faddr] = wv[7:0];
        end
        REG_INSTR, REG_STATUS, REG_PC: begin
        end
        default: s_next.bresp = RESP_SLVERR;
      endcase
    end
    if (issue) begin
      s_next.ir = ir_new;
      s_next.pc = s_reg.pc + 13'h0001;
      if (file_we) begin
        s_next.mem[file_idx] = alu_res;
        if ((file_idx == TIMER_ZERO_ADDR) && s_reg.presc_assigned) begin
          s_next.presc_clear = 1'b1;
        end
      end
      case (cls)
        nibble_exchange_op, acc_file_xor_op: begin
          if (!ir_new[7]) s_next.wreg = alu_res;
          if (cls == acc_file_xor_op) s_next.flags[FLAG_ZERO] = alu_z;
        end
        test_skip_clear_op, test_skip_set_op: begin
          if (skip_bit == (cls == test_skip_set_op)) begin
            s_next.st = st_flush;
            s_next.pc = s_reg.pc + 13'h0002;
          end
        end
        subroutine_jump_op, branch_op: begin
          if (cls == subroutine_jump_op) begin
            s_next.stack[s_reg.sp] = s_reg.pc + 13'h0001;
            s_next.sp = SP_W'(s_reg.sp + 1'b1);
          end
          s_next.pc = {s_reg.pc[12:11], ir_new[10:0]};
          s_next.st = st_flush;
        end
        literal_add_op, literal_minus_acc_op: begin
          s_next.wreg = alu_res;
          s_next.flags[FLAG_CARRY] = alu_c;
          s_next.flags[FLAG_HALF_CARRY] = alu_dc;
          s_next.flags[FLAG_ZERO] = alu_z;
        end
        literal_and_op, literal_or_op, literal_xor_op: begin
          s_next.wreg = alu_res;
          s_next.flags[FLAG_ZERO] = alu_z;
        end
        literal_load_op: begin
          s_next.wreg = alu_res;
        end
        return_literal_op, plain_return_op, interrupt_return_op: begin
          // Stack wraps silently on underflow, as it does on overflow
          if (cls == return_literal_op) s_next.wreg = alu_res;
          if (cls == interrupt_return_op) s_next.gie = 1'b1;
          s_next.sp = SP_W'(s_reg.sp - 1'b1);
          s_next.pc = s_reg.stack[SP_W'(s_reg.sp - 1'b1)];
          s_next.st = st_flush;
        end
        standby_op: begin
          s_next.sleep = 1'b1;
          s_next.wdt_restart = 1'b1;
          s_next.flags[FLAG_WATCHDOG_EXPIRED] = 1'b1;
          s_next.flags[FLAG_SLEEP_ENTERED] = 1'b0;
        end
        watchdog_kick_op: begin
          s_next.wdt_restart = 1'b1;
          s_next.flags[FLAG_WATCHDOG_EXPIRED] = 1'b1;
          s_next.flags[FLAG_SLEEP_ENTERED] = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.flags <= FLAGS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign awready = !s_reg.aw_got && !s_reg.bvalid;
  assign wready = !s_reg.w_got && !s_reg.bvalid;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = !s_reg.rvalid;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign port_latch = s_reg.mem[IO_PORT_ADDR];
  assign prescaler_clear = s_reg.presc_clear;
  assign watchdog_restart = s_reg.wdt_restart;
  assign sleep_state = s_reg.sleep;
  assign interrupts_enabled = s_reg.gie;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_flush_then_ready;
    (s_reg.st == st_flush) ##1 (s_reg.st == st_ready);
  endsequence

  property p_skip_clear;
    issue && (cls == test_skip_clear_op) |=> ((s_reg.st == st_flush) == !$past(skip_bit));
  endproperty
  a_skip_clear: assert property (p_skip_clear) else $error("skip on clear bit wrong");

  property p_skip_set;
    issue && (cls == test_skip_set_op) && skip_bit |=>
      (s_reg.pc == $past(s_reg.pc) + 13'h0002) ##0 s_flush_then_ready;
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip on set bit wrong");

  property p_jump;
    issue && ((cls == branch_op) || (cls == subroutine_jump_op)) |=>
      (s_reg.pc[10:0] == $past(ir_new[10:0])) ##0 s_flush_then_ready;
  endproperty
  a_jump: assert property (p_jump) else $error("jump not two cycles");

  property p_flush_quiet;
    s_reg.st == st_flush |=> $stable(s_reg.wreg) && $stable(s_reg.flags) &&
      $stable(s_reg.mem) && $stable(s_reg.pc);
  endproperty
  a_flush_quiet: assert property (p_flush_quiet) else $error("no-op cycle changed state");

  property p_port_pins;
    issue && (file_idx == IO_PORT_ADDR) && (ir_new[13:12] != 2'b11) |-> src == pin_level;
  endproperty
  a_port_pins: assert property (p_port_pins) else $error("port source not pins");

  property p_presc;
    file_we && (file_idx == TIMER_ZERO_ADDR) && s_reg.presc_assigned |=>
      prescaler_clear ##1 !prescaler_clear;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler not cleared");

  property p_swap;
    issue && (cls == nibble_exchange_op) && !ir_new[7] |=>
      (s_reg.wreg == $past(src_swapped)) && $stable(s_reg.flags);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble exchange wrong");

  property p_xor_file;
    issue && (cls == acc_file_xor_op) && ir_new[7] |=>
      (s_reg.mem[$past(file_idx)] == $past(alu_res)) && $stable(s_reg.wreg);
  endproperty
  a_xor_file: assert property (p_xor_file) else $error("file destination wrong");

  property p_lit_minus;
    issue && (cls == literal_minus_acc_op) |=>
      (s_reg.wreg == $past(ir_new[7:0]) - $past(s_reg.wreg)) &&
      (s_reg.flags[FLAG_ZERO] == (s_reg.wreg == 8'h00));
  endproperty
  a_lit_minus: assert property (p_lit_minus) else $error("literal minus wrong");

  property p_standby;
    issue && (cls == standby_op) |=> sleep_state && s_reg.flags[FLAG_WATCHDOG_EXPIRED] &&
      !s_reg.flags[FLAG_SLEEP_ENTERED] && watchdog_restart && (s_reg.st == st_ready);
  endproperty
  a_standby: assert property (p_standby) else $error("standby entry wrong");

endmodule
`default_nettype wire

// File: verification/tb_bit_literal_control_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
`define CR(a, e) rdr(a); `CHK(rd, e)
module tb_bit_literal_control_decoder;
  import bit_literal_pkg::*;
  logic clk_sys, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic prescaler_clear, watchdog_restart, sleep_state, interrupts_enabled;
  logic [7:0] awaddr, araddr, pin_level, port_latch;
  logic [31:0] wdata, rdata, rd, s;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  int mismatches, compares, pc_e, pc_s, n_pre, n_wd;

  bit_literal_control_decoder uut (.clk_sys, .resetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .pin_level, .port_latch, .prescaler_clear, .watchdog_restart,
    .sleep_state, .interrupts_enabled);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Pulses last one cycle, so count them here rather than poll from the tasks
  always @(posedge clk_sys) begin
    if (prescaler_clear === 1'b1) n_pre++;
    if (watchdog_restart === 1'b1) n_wd++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic tick(inout int n);
    n++;
    if (n > 200) begin
      mismatches++;
      $display("ERROR %0t: timeout", $time);
      give_verdict();
    end
  endtask

  // Readies are looked at mid-cycle, where they are settled, and honoured at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd, ha, hw;
    int n;
    ad = 0;
    wd = 0;
    n = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clk_sys);
      ha = awvalid && awready;
      hw = wvalid && wready;
      @(posedge clk_sys);
      if (ha) begin
        awvalid <= 1'b0;
        ad = 1;
      end
      if (hw) begin
        wvalid <= 1'b0;
        wd = 1;
      end
      tick(n);
    end
    do begin
      @(negedge clk_sys);
      ha = bvalid;
      rsp = bresp;
      @(posedge clk_sys);
      tick(n);
    end while (!ha);
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    bit h;
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk_sys);
      h = arready;
      @(posedge clk_sys);
      tick(n);
    end while (!h);
    arvalid <= 1'b0;
    do begin
      @(negedge clk_sys);
      h = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge clk_sys);
      tick(n);
    end while (!h);
    rready <= 1'b0;
  endtask

  task automatic ex(input logic [13:0] i);
    wr(REG_INSTR, {18'h0, i});
    pc_e++;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdr(REG_STATUS);
    `CHK(rd[10:0], 11'h018)
    `CR(REG_PC, 32'h0)
    `CR(8'h40, 32'h0)
    `CHK(rsp, RESP_SLVERR)
    wr(8'h40, 32'h1);
    `CHK(rsp, RESP_SLVERR)
    $display("test reset done");
  endtask

  task automatic t_literal;
    ex(14'h303c);
    `CR(REG_WORK, 32'h3c)
    ex(14'h3881);
    `CR(REG_WORK, 32'hbd)
    ex(14'h3000 | 14'h05);
    ex(14'h3c03);
    `CR(REG_STATUS, 32'h018)
    `CR(REG_WORK, 32'hfe)
    ex(14'h3005);
    ex(14'h3d15);
    `CR(REG_STATUS, 32'h01b)
    ex(14'h39f0);
    ex(14'h3ef0);
    `CR(REG_STATUS, 32'h01d)
    ex(14'h3a55);
    `CR(REG_WORK, 32'h55)
    `CR(REG_STATUS, 32'h019)
    $display("test literal done");
  endtask

  task automatic t_bits;
    wr(REG_FADDR, 32'h20);
    wr(REG_FDATA, 32'h05);
    ex(14'h1020);
    ex(14'h14a0);
    `CR(REG_FDATA, 32'h06)
    `CR(REG_STATUS, 32'h019)
    ex(14'h1820);
    pc_e++;
    ex(14'h18a0);
    `CR(REG_PC, pc_e)
    ex(14'h1d20);
    pc_e++;
    ex(14'h1c20);
    `CR(REG_PC, pc_e)
    $display("test bits done");
  endtask

  task automatic t_file;
    wr(REG_FADDR, 32'h21);
    wr(REG_FDATA, 32'ha5);
    ex(14'h303c);
    rdr(REG_STATUS);
    s = rd;
    ex(14'h0e21);
    `CR(REG_WORK, 32'h5a)
    `CR(REG_STATUS, s)
    ex(14'h0ea1);
    `CR(REG_FDATA, 32'h5a)
    ex(14'h0621);
    `CR(REG_WORK, 32'h0)
    `CR(REG_STATUS, s | 32'h4)
    ex(14'h30ff);
    ex(14'h06a1);
    `CR(REG_FDATA, 32'ha5)
    `CR(REG_WORK, 32'hff)
    wr(REG_FADDR, 32'h06);
    wr(REG_FDATA, 32'hff);
    pin_level <= 8'h0f;
    ex(14'h0e86);
    `CHK(port_latch, 8'hf0)
    wr(REG_CTRL, 32'h1);
    s = n_pre;
    ex(14'h1401);
    `CR(REG_WORK, 32'hff)
    `CHK(n_pre, s + 1)
    ex(14'h0e01);
    wr(REG_CTRL, 32'h0);
    ex(14'h1481);
    `CHK(n_pre, s + 1)
    $display("test file done");
  endtask

  task automatic t_flow;
    rdr(REG_STATUS);
    s = rd;
    pc_s = pc_e;
    ex(14'h2100);
    pc_e = 32'h100;
    `CR(REG_PC, pc_e)
    `CR(REG_STATUS, s)
    ex(14'h2a00);
    pc_e = 32'h200;
    `CR(REG_PC, pc_e)
    `CR(REG_WORK, 32'h10)
    ex(14'h3477);
    `CR(REG_WORK, 32'h77)
    `CR(REG_PC, pc_s + 1)
    ex(14'h2050);
    ex(14'h0008);
    `CR(REG_PC, pc_s + 2)
    `CHK(interrupts_enabled, 1'b0)
    ex(14'h2050);
    ex(14'h0009);
    `CR(REG_PC, pc_s + 3)
    `CHK(interrupts_enabled, 1'b1)
    $display("test flow done");
  endtask

  task automatic t_sleep;
    s = n_wd;
    ex(14'h0063);
    `CHK(sleep_state, 1'b1)
    rdr(REG_STATUS);
    `CHK(rd[4:3], 2'b10)
    ex(14'h3011);
    `CR(REG_WORK, 32'h77)
    wr(REG_CTRL, 32'h2);
    `CHK(sleep_state, 1'b0)
    ex(14'h0064);
    rdr(REG_STATUS);
    `CHK(rd[4:3], 2'b11)
    `CHK(n_wd, s + 2)
    $display("test sleep done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    pin_level = 8'h00;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_literal();
    t_bits();
    t_file();
    t_flow();
    t_sleep();
    give_verdict();
  end
endmodule
`default_nettype wire
